// *** design/timer_ctrl_pkg.sv ***
// Purpose: Constants and carrier types for the timer control block
// Assumes: AXI4-Lite register bus, 32-bit data, one register per word
// Notes: Register offsets are byte addresses
package timer_ctrl_pkg;
    localparam logic [4:0] status_control_off = 5'h00;
    localparam logic [4:0] count_high_off = 5'h04;
    localparam logic [4:0] count_low_off = 5'h08;
    localparam logic [4:0] modulo_high_off = 5'h0C;
    localparam logic [4:0] modulo_low_off = 5'h10;
    localparam logic [4:0] debug_control_off = 5'h14;
    localparam int overflow_flag_bit = 7;
    localparam int overflow_irq_enable_bit = 6;
    localparam int center_align_select_bit = 5;
    localparam int clock_source_lsb = 3;
    localparam int prescale_lsb = 0;
    localparam logic [7:0] status_control_reset = 8'h00;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam logic [15:0] modulo_reset = 16'h0000;
    localparam logic [15:0] count_top = 16'hFFFF;
    localparam logic [15:0] count_top_minus_one = 16'hFFFE;
    localparam logic [1:0] axi_resp_okay = 2'b00;
    localparam logic [1:0] axi_resp_slverr = 2'b10;

    typedef enum logic [1:0] {
        clk_src_none = 2'b00,
        clk_src_bus = 2'b01,
        clk_src_fixed = 2'b10,
        clk_src_external = 2'b11
    } clock_source_t;

    typedef struct packed {
        logic overflow_flag;
        logic overflow_irq_enable;
        logic center_align_select;
        clock_source_t clock_source_select;
        logic [2:0] prescale_select;
    } status_control_t;

    typedef struct packed {
        logic [15:0] count;
        logic count_down;
        logic center_align_select;
    } channel_link_t;
endpackage : timer_ctrl_pkg

// *** design/timer_counter_control_regs.sv ***
// Purpose: Timer status/control, coherent counter and buffered modulo
// Assumes: One 20 MHz clock; external and fixed clocks sampled as pins
// Notes: Channel logic sits outside and uses the channel link output
`timescale 1ns/10ps
module timer_counter_control_regs
    import timer_ctrl_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic fixed_clock_i,
    input wire logic external_clock_i,
    input wire logic background_debug_mode_i,
    input wire logic [4:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [4:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic overflow_irq_o,
    output channel_link_t channel_link_o
);

    ////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Three stages; a change counts once stages two and three agree
    logic [2:0] fix_sync_r, ext_sync_r, dbg_sync_r;
    logic fix_level_r, ext_level_r, dbg_level_r;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            fix_sync_r <= 3'b000;
            ext_sync_r <= 3'b000;
            dbg_sync_r <= 3'b000;
            fix_level_r <= 1'b0;
            ext_level_r <= 1'b0;
            dbg_level_r <= 1'b0;
        end else begin
            fix_sync_r <= {fix_sync_r[1:0], fixed_clock_i};
            ext_sync_r <= {ext_sync_r[1:0], external_clock_i};
            dbg_sync_r <= {dbg_sync_r[1:0], background_debug_mode_i};
            if (fix_sync_r[1] == fix_sync_r[2]) begin
                fix_level_r <= fix_sync_r[2];
            end
            if (ext_sync_r[1] == ext_sync_r[2]) begin
                ext_level_r <= ext_sync_r[2];
            end
            if (dbg_sync_r[1] == dbg_sync_r[2]) begin
                dbg_level_r <= dbg_sync_r[2];
            end
        end
    end

    // Rising edges of the filtered pin clocks
    logic fix_prev_r, ext_prev_r;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            fix_prev_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            fix_prev_r <= fix_level_r;
            ext_prev_r <= ext_level_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: accepts address and data in either order
    logic aw_held_r, w_held_r, ar_busy_r;
    logic [4:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_fire, rd_fire;
    logic [4:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_mapped;

    assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_held_r && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid_o;
    assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
    assign rd_addr = s_axi_araddr_i;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 5'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_i;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Byte lane 0 carries each register; other lanes are ignored
    logic wr_lane0;
    logic wr_sc, wr_cnt, wr_modh, wr_modl, wr_dbgctl, wr_mapped;
    assign wr_lane0 = wr_fire && w_strb_r[0];
    assign wr_sc = wr_lane0 && aw_addr_r == status_control_off;
    assign wr_cnt = wr_lane0 && (aw_addr_r == count_high_off ||
                                 aw_addr_r == count_low_off);
    assign wr_modh = wr_lane0 && aw_addr_r == modulo_high_off;
    assign wr_modl = wr_lane0 && aw_addr_r == modulo_low_off;
    assign wr_dbgctl = wr_lane0 && aw_addr_r == debug_control_off;
    assign wr_mapped = aw_addr_r <= debug_control_off &&
                       aw_addr_r[1:0] == 2'b00;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= axi_resp_okay;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_mapped ? axi_resp_okay : axi_resp_slverr;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status/control register
    status_control_t sc_r;
    logic [15:0] count_r, modulo_r;
    logic count_down_r;
    logic tick, overflow_evt;
    logic flag_armed_r;
    logic sw_debug_r;
    logic debug_active;
    assign debug_active = dbg_level_r || sw_debug_r;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sw_debug_r <= 1'b0;
        end else if (wr_dbgctl) begin
            sw_debug_r <= w_data_r[0];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sc_r <= status_control_t'(status_control_reset);
        end else begin
            if (wr_sc) begin
                sc_r.overflow_irq_enable <= w_data_r[overflow_irq_enable_bit];
                sc_r.center_align_select <= w_data_r[center_align_select_bit];
                sc_r.clock_source_select <=
                    clock_source_t'(w_data_r[clock_source_lsb +: 2]);
                sc_r.prescale_select <= w_data_r[prescale_lsb +: 3];
            end
            // Set beats clear in the same cycle
            if (overflow_evt) begin
                sc_r.overflow_flag <= 1'b1;
            end else if (wr_sc && flag_armed_r &&
                         !w_data_r[overflow_flag_bit]) begin
                sc_r.overflow_flag <= 1'b0;
            end
        end
    end

    // Read-while-set arms the clear; a new overflow disarms it
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            flag_armed_r <= 1'b0;
        end else if (overflow_evt) begin
            flag_armed_r <= 1'b0;
        end else if (rd_fire && rd_addr == status_control_off &&
                     sc_r.overflow_flag) begin
            flag_armed_r <= 1'b1;
        end else if (wr_sc) begin
            flag_armed_r <= 1'b0;
        end
    end

    assign overflow_irq_o = sc_r.overflow_irq_enable &&
                            sc_r.overflow_flag;

    ////////////////////////////////////////////////////////////////////
    // Clock selection and prescaler
    logic src_edge;
    logic [6:0] presc_r;
    logic [6:0] presc_mask;
    always_comb begin
        case (sc_r.clock_source_select)
            clk_src_none: src_edge = 1'b0;
            clk_src_bus: src_edge = 1'b1;
            clk_src_fixed: src_edge = fix_level_r && !fix_prev_r;
            clk_src_external: src_edge = ext_level_r && !ext_prev_r;
            default: src_edge = 1'b0;
        endcase
    end

    // Mask of low bits that must all be one, 2**ps source edges
    assign presc_mask = 7'((8'h01 << sc_r.prescale_select) - 8'h01);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            presc_r <= 7'h00;
        end else if (src_edge && !debug_active) begin
            presc_r <= 7'(presc_r + 7'h01);
        end
    end
    assign tick = src_edge && !debug_active &&
                  (presc_r & presc_mask) == presc_mask;

    ////////////////////////////////////////////////////////////////////
    // Counter
    logic mod_free;
    logic [15:0] top;
    logic wrap_up;
    assign mod_free = modulo_r == modulo_reset ||
                      modulo_r == count_top;
    assign top = mod_free ? count_top : modulo_r;
    assign wrap_up = tick && !sc_r.center_align_select &&
                     count_r == top;

    logic half_written;
    assign overflow_evt = !half_written &&
        (wrap_up || (tick && sc_r.center_align_select && count_down_r &&
                     count_r == count_reset));

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= count_reset;
            count_down_r <= 1'b0;
        end else if (wr_cnt) begin
            count_r <= count_reset;
            count_down_r <= 1'b0;
        end else if (!sc_r.center_align_select) begin
            // Leaving center mode drops the direction even when stopped
            count_down_r <= 1'b0;
            if (tick) begin
                count_r <= wrap_up ? count_reset :
                           16'(count_r + 16'h0001);
            end
        end else if (tick) begin
            if (count_down_r) begin
                if (count_r == count_reset) begin
                    count_down_r <= 1'b0;
                    count_r <= 16'(count_r + 16'h0001);
                end else begin
                    count_r <= 16'(count_r - 16'h0001);
                end
            end else if (count_r >= top) begin
                count_down_r <= 1'b1;
                count_r <= 16'(count_r - 16'h0001);
            end else begin
                count_r <= 16'(count_r + 16'h0001);
            end
        end
    end

    assign channel_link_o = '{count: count_r, count_down: count_down_r,
                              center_align_select: sc_r.center_align_select};

    ////////////////////////////////////////////////////////////////////
    // Read coherency latch
    logic cnt_latched_r;
    logic [15:0] cnt_hold_r;
    logic [15:0] cnt_view;
    logic rd_cnt;
    assign rd_cnt = rd_fire && (rd_addr == count_high_off ||
                                rd_addr == count_low_off);
    assign cnt_view = cnt_latched_r ? cnt_hold_r : count_r;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            cnt_latched_r <= 1'b0;
            cnt_hold_r <= count_reset;
        end else if (wr_sc || wr_cnt) begin
            cnt_latched_r <= 1'b0;
        end else if (rd_cnt && !debug_active) begin
            // Second byte read releases; first captures both bytes
            if (cnt_latched_r) begin
                cnt_latched_r <= 1'b0;
            end else begin
                cnt_latched_r <= 1'b1;
                cnt_hold_r <= count_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Modulo write buffer
    logic [7:0] mod_buf_hi_r, mod_buf_lo_r;
    logic hi_wr_r, lo_wr_r, load_pend_r;
    logic step_to_top;
    assign half_written = hi_wr_r ^ lo_wr_r;
    // Counter about to step from top-1 to top
    assign step_to_top = tick && !count_down_r &&
        count_r == (mod_free ? count_top_minus_one :
                    16'(modulo_r - 16'h0001));

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            modulo_r <= modulo_reset;
            mod_buf_hi_r <= 8'h00;
            mod_buf_lo_r <= 8'h00;
            hi_wr_r <= 1'b0;
            lo_wr_r <= 1'b0;
            load_pend_r <= 1'b0;
        end else if (wr_sc) begin
            hi_wr_r <= 1'b0;
            lo_wr_r <= 1'b0;
            load_pend_r <= 1'b0;
        end else if (debug_active) begin
            // Latches hold; writes go straight through
            if (wr_modh) begin
                modulo_r[15:8] <= w_data_r[7:0];
            end
            if (wr_modl) begin
                modulo_r[7:0] <= w_data_r[7:0];
            end
        end else if (wr_modh || wr_modl) begin
            if (wr_modh) begin
                mod_buf_hi_r <= w_data_r[7:0];
            end
            if (wr_modl) begin
                mod_buf_lo_r <= w_data_r[7:0];
            end
            if ((wr_modh && lo_wr_r) || (wr_modl && hi_wr_r)) begin
                hi_wr_r <= 1'b0;
                lo_wr_r <= 1'b0;
                if (sc_r.clock_source_select == clk_src_none) begin
                    modulo_r <= wr_modh ? {w_data_r[7:0], mod_buf_lo_r}
                                        : {mod_buf_hi_r, w_data_r[7:0]};
                end else begin
                    load_pend_r <= 1'b1;
                end
            end else begin
                hi_wr_r <= hi_wr_r || wr_modh;
                lo_wr_r <= lo_wr_r || wr_modl;
            end
        end else if (load_pend_r &&
                     (step_to_top ||
                      sc_r.clock_source_select == clk_src_none)) begin
            modulo_r <= {mod_buf_hi_r, mod_buf_lo_r};
            load_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (rd_addr)
            status_control_off: rd_data[7:0] = sc_r;
            count_high_off: rd_data[7:0] = cnt_view[15:8];
            count_low_off: rd_data[7:0] = cnt_view[7:0];
            modulo_high_off: rd_data[7:0] = modulo_r[15:8];
            modulo_low_off: rd_data[7:0] = modulo_r[7:0];
            debug_control_off: rd_data[1:0] = {dbg_level_r, sw_debug_r};
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= axi_resp_okay;
        end else if (rd_fire) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_data;
            s_axi_rresp_o <= rd_mapped ? axi_resp_okay : axi_resp_slverr;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
endmodule : timer_counter_control_regs

// *** test/timer_ctrl_sva.sv ***
// Purpose: Port-level assertions for the timer control register block
// Assumes: One clock; reset_n_i active low
// Notes: Bound to every instance of the block
`timescale 1ns/10ps
module timer_ctrl_sva
    import timer_ctrl_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic background_debug_mode_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [4:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input channel_link_t channel_link_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    logic bad_addr;
    assign bad_addr = s_axi_araddr_i > debug_control_off
        || s_axi_araddr_i[1:0] != 2'h0;
    sequence ar_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    // Pin passes three sync flops, so allow five samples
    sequence dbg_held;
        background_debug_mode_i [*5];
    endsequence
    a_read_answer: assert property (ar_taken |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while busy");
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write answer dropped");
    a_write_blocked: assert property (s_axi_bvalid_o
        |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while busy");
    a_bad_addr: assert property (ar_taken ##0 bad_addr
        |=> s_axi_rresp_o == axi_resp_slverr)
        else $error("bad address not refused");
    a_byte_read: assert property (ar_taken ##0 !bad_addr
        |=> s_axi_rresp_o == axi_resp_okay && s_axi_rdata_o[31:8] == 24'h00_0000)
        else $error("mapped read wrong");
    a_count_step: assert property ($changed(channel_link_o.count) |->
        channel_link_o.count == $past(channel_link_o.count) + 16'h0001
        || channel_link_o.count == $past(channel_link_o.count) - 16'h0001
        || channel_link_o.count == count_reset)
        else $error("counter jumped");
    a_up_only: assert property (!channel_link_o.center_align_select
        && $past(!channel_link_o.center_align_select)
        |-> !channel_link_o.count_down)
        else $error("down count outside center mode");
    a_debug_freeze: assert property (dbg_held |=>
        $stable(channel_link_o.count) || channel_link_o.count == count_reset)
        else $error("counter moved in debug");
endmodule : timer_ctrl_sva

bind timer_counter_control_regs timer_ctrl_sva timer_ctrl_sva_inst (
    .clock_i(clock_i), .reset_n_i(reset_n_i),
    .background_debug_mode_i(background_debug_mode_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .channel_link_o(channel_link_o)
);

// *** test/test_timer_counter_control_regs.sv ***
// Purpose: Self-checking bench for the timer control register block
// Assumes: Inputs change at rising edges; readies sampled at falling edges
// Notes: Bus answers are queued by the drivers and popped by a monitor
`timescale 1ns/10ps
module test_timer_counter_control_regs;
    import timer_ctrl_pkg::*;
    logic clock_i = 1'h0, reset_n_i = 1'h0, fixed = 1'h0, ext = 1'h0;
    logic dbg = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid;
    logic arready, rvalid, irq;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, r, rv;
    logic [1:0] bresp, rresp;
    logic [15:0] c;
    channel_link_t link;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [3:0] pin_cnt = 4'h0;
    int mismatches = 0, comparisons = 0, seed = 65809, i, mx, dn;
    logic [7:0] cfg[6] = '{8'h08, 8'h0B, 8'h0F, 8'h10, 8'h18, 8'h00};
    int gaps[6] = '{1, 8, 128, 8, 16, 400};
    timer_counter_control_regs timer_counter_control_regs_inst (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .fixed_clock_i(fixed),
        .external_clock_i(ext), .background_debug_mode_i(dbg),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .overflow_irq_o(irq),
        .channel_link_o(link)
    );
    initial forever #25 clock_i = ~clock_i;
    // Pin clocks of 8 and 16 cycles, well under a quarter of the bus rate
    always @(posedge clock_i) begin
        pin_cnt <= pin_cnt + 4'h1;
        fixed <= pin_cnt[2];
        ext <= pin_cnt[3];
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [33:0] e,
        input logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bail(input logic ok);
        if (!ok) begin
            mismatches++;
            stop_test();
        end
    endtask : bail
    // Error data are unspecified, so only the code is compared then
    always @(posedge clock_i) begin
        if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
        if (rvalid && rready) begin
            rv = (rq[0][33:32] == axi_resp_slverr) ? rq[0][31:0] : rdata;
            chk("rdata", rq.pop_front(), {rresp, rv});
        end
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        int n;
        @(posedge clock_i);
        bq.push_back(a > debug_control_off ? axi_resp_slverr : axi_resp_okay);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        tb = 1'h0;
        for (n = 0; n < 64 && !tb; n++) begin
            @(negedge clock_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge clock_i);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        bail(tb);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] d,
        input logic [1:0] rs);
        logic ta, tr;
        int n;
        @(posedge clock_i);
        rq.push_back({rs, 24'h00_0000, d});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        tr = 1'h0;
        for (n = 0; n < 64 && !tr; n++) begin
            @(negedge clock_i);
            ta = arvalid && arready;
            tr = rvalid;
            @(posedge clock_i);
            if (ta) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        bail(tr);
    endtask : rd
    // Second interval between counter changes; 400 means no tick at all
    task automatic gap(input int e);
        int n, k;
        for (k = 0; k < 2; k++) begin
            c = link.count;
            n = 0;
            while (link.count === c && n < 400) begin
                @(posedge clock_i);
                n++;
            end
        end
        chk("tick gap", e, n);
    endtask : gap
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'h1;
        repeat (3) @(posedge clock_i);
        rd(status_control_off, 8'h00, axi_resp_okay);
        rd(count_high_off, 8'h00, axi_resp_okay);
        rd(modulo_high_off, 8'h00, axi_resp_okay);
        rd(modulo_low_off, 8'h00, axi_resp_okay);
        rd(5'h18, 8'h00, axi_resp_slverr);
        rd(5'h02, 8'h00, axi_resp_slverr);
        wr(5'h1C, 8'h00);
        r = $random(seed);
        wr(modulo_high_off, r[15:8]);
        wr(modulo_low_off, r[7:0]);
        rd(modulo_high_off, r[15:8], axi_resp_okay);
        rd(modulo_low_off, r[7:0], axi_resp_okay);
        wr(count_high_off, 8'h00);
        wr(modulo_high_off, 8'h00);
        wr(modulo_low_off, 8'h03);
        wr(status_control_off, 8'h48);
        repeat (20) @(posedge clock_i);
        wr(status_control_off, 8'h40);
        rd(status_control_off, 8'hC0, axi_resp_okay);
        chk("irq", 1'h1, irq);
        wr(status_control_off, 8'h40);
        rd(status_control_off, 8'h40, axi_resp_okay);
        chk("irq", 1'h0, irq);
        wr(count_high_off, r[23:16]);
        rd(count_high_off, 8'h00, axi_resp_okay);
        rd(count_low_off, 8'h00, axi_resp_okay);
        wr(status_control_off, 8'h08);
        repeat (20) @(posedge clock_i);
        wr(status_control_off, 8'h00);
        rd(status_control_off, 8'h80, axi_resp_okay);
        chk("irq", 1'h0, irq);
        wr(status_control_off, 8'h80);
        rd(status_control_off, 8'h80, axi_resp_okay);
        wr(count_low_off, r[31:24]);
        wr(status_control_off, 8'h28);
        mx = 0;
        dn = 0;
        repeat (40) begin
            @(posedge clock_i);
            if (link.count > mx) mx = link.count;
            if (link.count_down === 1'h1) dn = 1;
        end
        chk("center top", 3, mx);
        chk("down seen", 1, dn);
        wr(status_control_off, 8'h00);
        wr(modulo_high_off, 8'h00);
        wr(modulo_low_off, 8'h00);
        for (i = 0; i < 6; i++) begin
            wr(status_control_off, cfg[i]);
            gap(gaps[i]);
        end
        wr(status_control_off, 8'h08);
        dbg <= 1'h1;
        repeat (8) @(posedge clock_i);
        c = link.count;
        repeat (20) @(posedge clock_i);
        chk("frozen count", c, link.count);
        rd(debug_control_off, 8'h02, axi_resp_okay);
        dbg <= 1'h0;
        wr(status_control_off, 8'h00);
        stop_test();
    end
endmodule : test_timer_counter_control_regs
